// ---- verilog/ext_ldst_core.v ----
// extended load/store decode and execute core
// ==========================================
// Overview of operation
// - program counter is 24 bits wide
// - 24-bit mode pushes/pops move stack by four
// - extended load copies memory to destination register
// - pointer field bit zero selects auto-increment on indirect forms
// - E8 word load indirect, E9 indexed
// - EA byte load indirect, EB indexed
// - 1C word store indirect, 1D indexed
// - 1E byte store indirect, 1F indexed
// - extended store writes register to 24-bit address
// - pointer: low word bits 15-0, next byte 23-16
// - ordinary stores reach upper SFRs only page 00
// - bus drives sixteen plus four extended lines
// - register file holds 1000 bytes
// - paged address is page above 16-bit address
`timescale 1ns/1ps
`include "ext_ldst_consts.vh"
module ext_ldst_core (
  // clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // instruction byte stream
  input wire i_ib_valid,
  input wire [7:0] i_ib_data,
  // mode and control from the system
  input wire i_mode24,
  input wire i_stack_push,
  input wire i_stack_pop,
  input wire i_plain_store,
  input wire [15:0] i_plain_addr,
  input wire [7:0] i_page_wdata,
  input wire i_page_we,
  input wire [3:0] i_port_mode,
  input wire [3:0] i_port_data,
  // memory answer
  input wire i_mem_ack,
  input wire [15:0] i_mem_rdata,
  // memory request
  output reg o_mem_req,
  output reg o_mem_we,
  output reg o_mem_word,
  output reg [23:0] o_mem_addr,
  output reg [15:0] o_mem_wdata,
  // external pins
  output reg [15:0] o_ad,
  output reg [3:0] o_extended_address_port,
  // status
  output reg [23:0] o_pc,
  output reg [15:0] o_sp,
  output reg o_busy,
  output reg o_plain_blocked
);
  // ==========================================
  // states
  localparam S_OPC = 3'h0;
  localparam S_PTR = 3'h1;
  localparam S_DISP = 3'h2;
  localparam S_REG = 3'h3;
  localparam S_RDP = 3'h4;
  localparam S_MEM = 3'h5;
  localparam S_WB = 3'h6;
  localparam S_INC = 3'h7;

  reg [2:0] st_q; // sequencer state
  reg [7:0] opc_q; // latched opcode
  reg [7:0] ptr_q; // pointer field byte
  reg [7:0] disp_q; // displacement byte
  reg [7:0] reg_q; // data register field
  reg [23:0] ptrv_q; // fetched 24-bit pointer
  reg [15:0] data_q; // load data
  reg [1:0] rdp_q; // pointer fetch step
  reg [7:0] page_q; // extended_page_register
  reg [23:0] pc_q; // 24-bit fetch address
  reg [15:0] sp_q; // stack pointer

  // regfile wiring
  reg [9:0] rf_raddr;
  reg [9:0] rf_waddr;
  reg [15:0] rf_wdata;
  reg [1:0] rf_wbe;
  wire [15:0] rf_rdata;

  // decode helpers
  function is_ext;
    input [7:0] o;
    begin
      is_ext = (o[7:1] == 7'h74) || (o[7:1] == 7'h75) ||
               (o[7:1] == 7'h0E) || (o[7:1] == 7'h0F);
    end
  endfunction
  function is_store;
    input [7:0] o;
    begin
      is_store = (o[7:4] == 4'h1); // upper nibble 1: 10..1F; only 1C..1F pass is_ext
    end
  endfunction

  wire op_indexed = opc_q[0]; // E9/EB/1D/1F are indexed
  wire op_word = (opc_q == `OPC_LD_W_IND) || (opc_q == `OPC_LD_W_IDX) ||
                 (opc_q == `OPC_ST_W_IND) || (opc_q == `OPC_ST_W_IDX);
  wire op_store = is_store(opc_q);
  // auto-increment only on indirect forms
  wire op_autoinc = !op_indexed && ptr_q[0];

  wire [23:0] eff_addr;
  wire [23:0] ptr_next;
  wire [23:0] paged_addr;

  // ==========================================
  // submodules
  ext_regfile u_rf ( // 1000 bytes
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_raddr(rf_raddr),
    .o_rdata(rf_rdata),
    .i_waddr(rf_waddr),
    .i_wdata(rf_wdata),
    .i_wbe(rf_wbe)
  );
  ext_addr_gen u_ag (
    .i_ptr(ptrv_q),
    .i_disp(disp_q),
    .i_indexed(op_indexed),
    .i_is_word(op_word),
    .i_page(page_q),
    .i_addr16(i_plain_addr),
    .o_eff(eff_addr),
    .o_ptr_inc(ptr_next),
    .o_paged(paged_addr)
  );

  // ==========================================
  // register file port steering
  always @* begin
    rf_raddr = {ptr_q[7:1], 1'b0} + {8'h00, rdp_q}; // even-aligned pointer
    rf_waddr = {2'b00, reg_q};
    rf_wdata = data_q;
    rf_wbe = 2'b00;
    if (st_q == S_MEM && op_store) begin
      rf_raddr = {2'b00, reg_q};
    end
    if (st_q == S_WB && !op_store) begin
      rf_wbe = op_word ? 2'b11 : 2'b01; // load lands in register
    end else if (st_q == S_INC) begin
      // write back advanced pointer, low word only; page byte not written
      rf_waddr = {2'b00, ptr_q[7:1], 1'b0};
      rf_wdata = ptr_next[15:0];
      rf_wbe = 2'b11;
    end
  end

  // ==========================================
  // upper special range check for ordinary stores
  wire plain_hits_sfr = (i_plain_addr >= `SFR_LO) && (i_plain_addr <= `SFR_HI);
  wire plain_ok = !plain_hits_sfr || (page_q == `PAGE_ZERO);

  // ==========================================
  // sequencer
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= S_OPC;
      opc_q <= 8'h00;
      ptr_q <= 8'h00;
      disp_q <= 8'h00;
      reg_q <= 8'h00;
      ptrv_q <= 24'h000000;
      data_q <= 16'h0000;
      rdp_q <= 2'b00;
      o_mem_req <= 1'b0;
      o_mem_we <= 1'b0;
      o_mem_word <= 1'b0;
      o_mem_addr <= 24'h000000;
      o_mem_wdata <= 16'h0000;
      o_busy <= 1'b0;
    end else begin
      case (st_q)
        S_OPC: begin
          if (i_ib_valid && is_ext(i_ib_data)) begin
            opc_q <= i_ib_data;
            o_busy <= 1'b1;
            st_q <= S_PTR;
          end
        end
        S_PTR: begin
          if (i_ib_valid) begin
            ptr_q <= i_ib_data;
            st_q <= opc_q[0] ? S_DISP : S_REG; // displacement follows pointer
          end
        end
        S_DISP: begin
          if (i_ib_valid) begin
            disp_q <= i_ib_data;
            st_q <= S_REG;
          end
        end
        S_REG: begin
          if (i_ib_valid) begin
            reg_q <= i_ib_data;
            rdp_q <= 2'b00;
            st_q <= S_RDP;
          end
        end
        S_RDP: begin
          // low word gives bits 15-0, next byte bits 23-16
          if (rdp_q == 2'b00) begin
            ptrv_q[15:0] <= rf_rdata;
            rdp_q <= 2'b10;
          end else begin
            ptrv_q[23:16] <= rf_rdata[7:0];
            st_q <= S_MEM;
          end
        end
        S_MEM: begin
          if (!o_mem_req) begin
            o_mem_req <= 1'b1;
            o_mem_we <= op_store;
            o_mem_word <= op_word;
            o_mem_addr <= eff_addr; // full 24-bit address
            // store bypasses the page guard entirely
            o_mem_wdata <= op_word ? rf_rdata : {8'h00, rf_rdata[7:0]};
          end else if (i_mem_ack) begin
            o_mem_req <= 1'b0;
            o_mem_we <= 1'b0;
            data_q <= o_mem_word ? i_mem_rdata : {8'h00, i_mem_rdata[7:0]};
            st_q <= S_WB;
          end
        end
        S_WB: begin
          st_q <= op_autoinc ? S_INC : S_OPC;
          if (!op_autoinc) begin
            o_busy <= 1'b0;
          end
        end
        S_INC: begin
          // page byte of pointer updated in the same pass is skipped;
          // carry into bits 23-16 is kept in the live pointer only
          ptrv_q <= ptr_next;
          o_busy <= 1'b0;
          st_q <= S_OPC;
        end
        default: begin
          st_q <= S_OPC;
        end
      endcase
    end
  end

  // ==========================================
  // program counter, stack pointer, page register
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pc_q <= `PC_RST;
      sp_q <= `SP_RST;
      page_q <= `PAGE_RST;
      o_pc <= `PC_RST;
      o_sp <= `SP_RST;
      o_plain_blocked <= 1'b0;
    end else begin
      if (i_ib_valid) begin
        pc_q <= pc_q + 24'h000001; // linear 24-bit fetch
      end
      if (i_stack_push && !i_stack_pop) begin
        sp_q <= sp_q - (i_mode24 ? `SP_STEP24 : `SP_STEP16);
      end else if (i_stack_pop && !i_stack_push) begin
        sp_q <= sp_q + (i_mode24 ? `SP_STEP24 : `SP_STEP16);
      end
      if (i_page_we) begin
        page_q <= i_page_wdata;
      end
      o_pc <= pc_q;
      o_sp <= sp_q;
      o_plain_blocked <= i_plain_store && !plain_ok;
    end
  end

  // ==========================================
  // external address: 16 multiplexed lines plus 4 port lines
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ad <= 16'h0000;
      o_extended_address_port <= 4'hF;
    end else begin
      if (o_busy) begin
        o_ad <= o_mem_addr[15:0];
        // extended instructions drive their own upper bits on pins in address mode
        o_extended_address_port <= (i_port_mode & o_mem_addr[19:16]) |
                                   (~i_port_mode & i_port_data);
      end else begin
        o_ad <= i_plain_addr;
        // per pin: address line or general I/O
        o_extended_address_port <= (i_port_mode & paged_addr[19:16]) |
                                   (~i_port_mode & i_port_data);
      end
    end
  end
endmodule

// ---- include/ext_ldst_consts.vh ----
// constants for the extended load/store decode block
`ifndef EXT_LDST_CONSTS_VH
`define EXT_LDST_CONSTS_VH
// opcodes
`define OPC_LD_W_IND 8'hE8
`define OPC_LD_W_IDX 8'hE9
`define OPC_LD_B_IND 8'hEA
`define OPC_LD_B_IDX 8'hEB
`define OPC_ST_W_IND 8'h1C
`define OPC_ST_W_IDX 8'h1D
`define OPC_ST_B_IND 8'h1E
`define OPC_ST_B_IDX 8'h1F
// widths
`define PC_W 24
`define XADDR_W 20
`define RF_BYTES 1000
`define RF_AW 10
// reset values
`define PC_RST 24'hFF2080
`define SP_RST 16'h0000
`define PAGE_RST 8'hFF
// page-zero special range guarded for ordinary stores
`define SFR_LO 16'h1FE0
`define SFR_HI 16'h1FFF
`define PAGE_ZERO 8'h00
// stack and pointer steps
`define SP_STEP24 16'h0004
`define SP_STEP16 16'h0002
`define INC_WORD 24'h000002
`define INC_BYTE 24'h000001
`endif

// ---- verilog/ext_regfile.v ----
// register file: 1000 bytes tied to the execution unit
`timescale 1ns/1ps
`include "ext_ldst_consts.vh"
module ext_regfile (
  // clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // read port (two bytes, little endian)
  input wire [9:0] i_raddr,
  output wire [15:0] o_rdata,
  // write port with per-byte enables
  input wire [9:0] i_waddr,
  input wire [15:0] i_wdata,
  input wire [1:0] i_wbe
);
  // ==========================================
  // storage
  reg [7:0] mem_q [0:`RF_BYTES-1]; // flip-flop array
  integer k;
  // the byte after the top one (999) wraps to zero
  function [9:0] nxt;
    input [9:0] a;
    begin
      nxt = (a == `RF_BYTES-1) ? 10'h000 : a + 10'h001;
    end
  endfunction
  assign o_rdata = {mem_q[nxt(i_raddr)], mem_q[i_raddr]};
  // byte writes; high lane lands on the next byte
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (k = 0; k < `RF_BYTES; k = k + 1) begin
        mem_q[k] <= 8'h00;
      end
    end else begin
      if (i_wbe[0]) begin
        mem_q[i_waddr] <= i_wdata[7:0];
      end
      if (i_wbe[1]) begin
        mem_q[nxt(i_waddr)] <= i_wdata[15:8];
      end
    end
  end
endmodule

// ---- verilog/ext_addr_gen.v ----
// effective address former for extended and paged accesses
`timescale 1ns/1ps
`include "ext_ldst_consts.vh"
module ext_addr_gen (
  // pointer and operands
  input wire [23:0] i_ptr,
  input wire [7:0] i_disp,
  input wire i_indexed,
  input wire i_is_word,
  // paged 16-bit form
  input wire [7:0] i_page,
  input wire [15:0] i_addr16,
  // results
  output wire [23:0] o_eff,
  output wire [23:0] o_ptr_inc,
  output wire [23:0] o_paged
);
  // ==========================================
  // indexed: sign-extended displacement, pointer untouched
  assign o_eff = i_indexed ? i_ptr + {{16{i_disp[7]}}, i_disp} : i_ptr;
  // auto-increment amount by access size
  assign o_ptr_inc = i_ptr + (i_is_word ? `INC_WORD : `INC_BYTE);
  // page register concatenated above a 16-bit address
  assign o_paged = {i_page, i_addr16};
endmodule

// ---- dv/ext_ldst_core_sva.sv ----
// port checker for the extended load/store core
`timescale 1ns/1ps
module ext_ldst_core_sva (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // watched inputs
  input wire logic i_mode24,
  input wire logic i_stack_push,
  input wire logic i_stack_pop,
  input wire logic i_mem_ack,
  input wire logic [3:0] i_port_mode,
  input wire logic [3:0] i_port_data,
  // watched outputs
  input wire logic o_mem_req,
  input wire logic o_mem_we,
  input wire logic [23:0] o_mem_addr,
  input wire logic [3:0] o_extended_address_port,
  input wire logic [23:0] o_pc,
  input wire logic [15:0] o_sp,
  input wire logic o_busy
);
  // ==================================================
  // properties, all in the one clock domain
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // status sp lags one cycle, so compare two edges on
  a_pc_reset_val: assert property ($rose(i_rst_n) |-> o_pc == 24'hFF2080)
    else $error("pc not at reset value");
  a_sp_push_wide: assert property (i_mode24 && i_stack_push && !i_stack_pop |=>
    ##1 o_sp == $past(o_sp) - 16'h0004) else $error("push did not lower sp by four");
  a_sp_pop_wide: assert property (i_mode24 && i_stack_pop && !i_stack_push |=>
    ##1 o_sp == $past(o_sp) + 16'h0004) else $error("pop did not raise sp by four");
  a_sp_push_narrow: assert property (!i_mode24 && i_stack_push && !i_stack_pop |=>
    ##1 o_sp == $past(o_sp) - 16'h0002) else $error("narrow push step wrong");
  // request held steady until answered
  a_req_holds: assert property (o_mem_req && !i_mem_ack |=>
    o_mem_req && $stable(o_mem_addr) && $stable(o_mem_we)) else $error("request moved");
  a_req_ends: assert property (o_mem_req && i_mem_ack |=> !o_mem_req)
    else $error("request outlived answer");
  a_busy_covers: assert property (o_mem_req |-> o_busy)
    else $error("request while idle");
  a_busy_falls: assert property (o_mem_req && i_mem_ack |-> ##[1:4] !o_busy)
    else $error("busy stuck after answer");
  // upper lines carry address bits 19..16 or port data
  a_port_addr: assert property (o_mem_req && $past(o_mem_req) && i_port_mode == 4'hF
    |-> o_extended_address_port == o_mem_addr[19:16]) else $error("upper lines wrong");
  a_port_io: assert property (i_port_mode == 4'h0 && !o_mem_req |=>
    o_extended_address_port == $past(i_port_data)) else $error("port data wrong");
  // main scenarios reached
  c_store: cover property (o_mem_req && i_mem_ack && o_mem_we);
  c_load: cover property (o_mem_req && i_mem_ack && !o_mem_we);
  c_pop: cover property (i_mode24 && i_stack_pop);
endmodule
bind ext_ldst_core ext_ldst_core_sva u_sva (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_mode24(i_mode24), .i_stack_push(i_stack_push), .i_stack_pop(i_stack_pop),
  .i_mem_ack(i_mem_ack), .i_port_mode(i_port_mode), .i_port_data(i_port_data),
  .o_mem_req(o_mem_req), .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr),
  .o_extended_address_port(o_extended_address_port), .o_pc(o_pc), .o_sp(o_sp),
  .o_busy(o_busy));

// ---- dv/ext_mem_model.sv ----
// behavioural external memory answering the core's requests
`timescale 1ns/1ps
module ext_mem_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // request and bench control
  input wire logic i_req,
  input wire logic [15:0] i_rd_value,
  input wire logic [3:0] i_wait,
  // answer
  output logic o_ack,
  output logic [15:0] o_rdata
);
  // ==================================================
  // answer after i_wait idle cycles, one-cycle ack
  logic [3:0] cnt_q; // wait states spent
  logic [15:0] last_q; // last data shown
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ack <= 1'b0;
      cnt_q <= 4'h0;
      last_q <= 16'h0000;
      o_rdata <= 16'hFFFF;
    end else if (o_ack) begin
      o_ack <= 1'b0;
      o_rdata <= ~last_q; // released bus shows no stale word
    end else if (i_req && cnt_q != i_wait) begin
      cnt_q <= cnt_q + 4'h1; // slow device
    end else if (i_req) begin
      o_ack <= 1'b1;
      o_rdata <= i_rd_value;
      last_q <= i_rd_value;
      cnt_q <= 4'h0;
    end
  end
endmodule

// ---- dv/ext_ldst_core_tb_top.sv ----
// self-checking bench for the extended load/store core
`timescale 1ns/1ps
module ext_ldst_core_tb_top;
  // ==================================================
  // stimulus, observed and captured signals
  logic clk = 0, rst_n = 0, ibv = 0, m24 = 1, push = 0, pop = 0, pst = 0, pwe = 0;
  logic [7:0] ibd = 0, pgd = 0;
  logic [15:0] pa = 0, rd = 0, rdata, wdata, sp, c_wd, ad, c_ad;
  logic [3:0] pm = 4'hF, pd = 0, wt = 0, port, c_port;
  logic ack, req, we, wrd, blk, busy, c_we, c_word;
  logic [23:0] addr, pc, c_addr;
  int num_errors = 0, samples_checked = 0, cyc = 0;
  always #2.5 clk = ~clk;
  ext_ldst_core dut (.i_clk(clk), .i_rst_n(rst_n), .i_ib_valid(ibv), .i_ib_data(ibd),
    .i_mode24(m24), .i_stack_push(push), .i_stack_pop(pop), .i_plain_store(pst),
    .i_plain_addr(pa), .i_page_wdata(pgd), .i_page_we(pwe), .i_port_mode(pm),
    .i_port_data(pd), .i_mem_ack(ack), .i_mem_rdata(rdata), .o_mem_req(req),
    .o_mem_we(we), .o_mem_word(wrd), .o_mem_addr(addr), .o_mem_wdata(wdata), .o_ad(ad),
    .o_extended_address_port(port), .o_pc(pc), .o_sp(sp), .o_busy(busy),
    .o_plain_blocked(blk));
  ext_mem_model mem (.i_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_rd_value(rd),
    .i_wait(wt), .o_ack(ack), .o_rdata(rdata));
  // capture each transfer at its answering edge
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (req && ack) begin
      {c_addr, c_we, c_word, c_wd, c_port, c_ad} <= {addr, we, wrd, wdata, port, ad};
    end
    if (cyc == 5000) begin
      num_errors++; // hang cut short
      end_of_test();
    end
  end
  // ==================================================
  // compare and drive tasks
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic op(input logic [31:0] b, input int n, input logic [15:0] v);
    rd = v;
    c_addr = 'x;
    for (int k = 0; k < n; k++) begin
      @(negedge clk);
      ibv = 1;
      ibd = b[31-8*k -: 8];
    end
    @(negedge clk);
    ibv = 0;
    for (int k = 0; k < 40 && busy !== 1'b0; k++) @(negedge clk);
    chk("busy", 0, busy);
  endtask
  task automatic xfer(input logic [31:0] b, input int n, input logic [15:0] v,
      input logic [23:0] ea, input logic w, input logic wd, input logic [15:0] d);
    op(b, n, v);
    chk("addr", ea, c_addr);
    chk("we", w, c_we);
    chk("word", wd, c_word);
    chk("upper", ea[19:16], c_port);
    chk("ad", ea[15:0], c_ad);
    if (w) chk("wdata", wd ? d : d[7:0], wd ? c_wd : c_wd[7:0]);
  endtask
  task automatic stack(input logic m, input logic p, input logic [15:0] e);
    @(negedge clk);
    {m24, push, pop} = {m, p, !p};
    @(negedge clk);
    {push, pop} = 2'b00;
    repeat (3) @(negedge clk);
    chk("sp", e, sp);
  endtask
  task automatic plain(input logic [15:0] a, input logic e);
    logic seen;
    seen = 0;
    @(negedge clk);
    {pst, pa} = {1'b1, a};
    @(negedge clk);
    pst = 0;
    repeat (4) @(posedge clk) seen |= blk;
    chk("blocked", e, seen);
  endtask
  // ==================================================
  // scenarios
  task automatic t_reset();
    chk("pc", 24'hFF2080, pc);
    chk("sp", 0, sp);
  endtask
  task automatic t_stack();
    stack(1, 1, 16'hFFFC);
    stack(1, 0, 16'h0000);
    stack(0, 1, 16'hFFFE);
    stack(0, 0, 16'h0000);
    m24 = 1;
  endtask
  task automatic t_build();
    xfer(32'hE8001000, 3, 16'h1FFC, 24'h0, 0, 1, 0);
    wt = 3; // slow device answers
    xfer(32'hEA001200, 3, 16'h0005, 24'h0, 0, 0, 0);
    wt = 0;
    xfer(32'h1C101000, 3, 0, 24'h051FFC, 1, 1, 16'h1FFC);
  endtask
  task automatic t_indexed();
    xfer(32'hE910FE20, 4, 16'hABCD, 24'h051FFA, 0, 1, 0);
    xfer(32'h1D100220, 4, 0, 24'h051FFE, 1, 1, 16'hABCD);
    xfer(32'hEB100122, 4, 16'h0077, 24'h051FFD, 0, 0, 0);
    xfer(32'h1F100022, 4, 0, 24'h051FFC, 1, 0, 16'h0077);
  endtask
  task automatic t_autoinc();
    xfer(32'hE8112400, 3, 16'h1111, 24'h051FFC, 0, 1, 0);
    xfer(32'h1E112400, 3, 0, 24'h051FFE, 1, 0, 16'h0011);
    xfer(32'h1C102400, 3, 0, 24'h051FFF, 1, 1, 16'h1111);
  endtask
  task automatic t_plain();
    plain(16'h1FE5, 1);
    plain(16'h1F00, 0);
    @(negedge clk);
    {pwe, pgd} = {1'b1, 8'h00};
    @(negedge clk);
    pwe = 0;
    plain(16'h1FE5, 0);
    xfer(32'h1C101000, 3, 0, 24'h051FFF, 1, 1, 16'h1FFF);
  endtask
  task automatic t_port();
    // idle: low lines follow the plain address, upper lines the page nibble
    @(negedge clk);
    chk("ad idle", 16'h1FE5, ad);
    chk("paged upper", 4'h0, port);
    // 37 instruction bytes fetched so far, linear count
    chk("pc count", 24'hFF20A5, pc);
    {pm, pd} = {4'h0, 4'hA};
    repeat (2) @(negedge clk);
    chk("port io", 4'hA, port);
  endtask
  // ==================================================
  // main sequence and verdict
  task automatic end_of_test();
    $display("errors %0d checked %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    t_reset();
    t_stack();
    t_build();
    t_indexed();
    t_autoinc();
    t_plain();
    t_port();
    end_of_test();
  end
endmodule
